// ==== test/nibble_serial_port_bench.sv ====
// Bench for the serial port core: APB master, far-end model, queued notes.
// Assumes the core answers APB with its own pready and pins idle high.
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %0t %h %h", $time, g, e); end end
module nibble_serial_port_bench
  import nsp_pkg::*;
;
  // Bus, pins and bookkeeping.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic chk_r = 1'b0;
  logic ext_go = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] pattern = 8'h00;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, sck_n_out, sck_n_oe, sdo_out, sdo_oe, sdi_line, sck_ext, serial_buffer_irq;
  logic [3:0] got, w;
  logic [7:0] p;
  logic [63:0] m;
  logic [63:0] q_rd[$];
  logic [3:0] q_ser[$];
  int got_cnt, k;
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 32'h3197500b;
  // A released data pin falls back to its pull-up; a released clock pin follows the far end.
  wire sck_line = (sck_n_oe === 1'b1) ? sck_n_out : sck_ext;
  wire sdo_line = (sdo_oe === 1'b1) ? sdo_out : 1'b1;
  always #20 pclk = ~pclk;
  nsp_core dut (.*, .sck_n_in(sck_line), .sdi_in(sdi_line));
  nsp_far_end far (.*);
  // Each checked read and each collected word takes the oldest note.
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite && chk_r)
    begin
      m = q_rd.size() ? q_rd.pop_front() : {32'hFFFFFFFF, 32'hXXXXXXXX};
      `CHK(prdata & m[63:32], m[31:0])
    end
  end
  always @(got_cnt)
    `CHK(got, q_ser.size() ? q_ser.pop_front() : 4'hX)
  // One transfer; held until pready is sampled high.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic c);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    chk_r <= c;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
    q_rd.push_back({mk, e});
    bus(1'b0, a, 32'h0, 1'b1);
  endtask
  task automatic poll(input int b);
    do bus(1'b0, NSP_ADDR_STAT, 32'h0, 1'b0);
    while (rdat[b] !== 1'b1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // A hang is cut off well past the expected run length.
  initial
  begin
    #1000000;
    n_mismatch++;
    results();
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(NSP_ADDR_CMD, 32'hF, 32'h0);
    bus(1'b1, 8'h10, 32'h0, 1'b0);
    bus(1'b1, NSP_ADDR_TXB, 32'h5, 1'b0);
    rd(NSP_ADDR_STAT, 32'hF, 32'h0);
    $display("reset test ended");
    // Two words on the internal clock; the clock then waits and is stopped.
    w = $random(seed);
    bus(1'b1, NSP_ADDR_CMD, 32'h3, 1'b0);
    bus(1'b1, NSP_ADDR_TXB, {28'h0, w}, 1'b0);
    q_ser.push_back(w);
    rd(NSP_ADDR_STAT, 32'hA, 32'h2);
    bus(1'b1, NSP_ADDR_CMD, 32'hB, 1'b0);
    poll(NSP_ST_IRQ);
    w = $random(seed);
    bus(1'b1, NSP_ADDR_TXB, {28'h0, w}, 1'b0);
    q_ser.push_back(w);
    rd(NSP_ADDR_STAT, 32'h9, 32'h8);
    wait (got_cnt == 2);
    repeat (600) @(posedge pclk);
    bus(1'b1, NSP_ADDR_CMD, 32'h3, 1'b0);
    rd(NSP_ADDR_STAT, 32'h8, 32'h0);
    $display("internal transmit test ended");
    // Two words per receive mode, stopped early once the second is shifting.
    for (k = NSP_MODE_RXT; k <= NSP_MODE_RXL; k++)
    begin
      p = $random(seed);
      pattern <= p;
      bus(1'b1, NSP_ADDR_CMD, {28'h0, 1'b1, k[1:0], 1'b1}, 1'b0);
      poll(NSP_ST_IRQ);
      poll(NSP_ST_SHF);
      bus(1'b1, NSP_ADDR_CMD, {28'h0, 1'b0, k[1:0], 1'b1}, 1'b0);
      rd(NSP_ADDR_RXB, 32'hF, {28'h0, p[3:0]});
      poll(NSP_ST_IRQ);
      rd(NSP_ADDR_RXB, 32'hF, {28'h0, p[7:4]});
      repeat (700) @(posedge pclk);
      rd(NSP_ADDR_STAT, 32'h9, 32'h0);
      $display("receive test ended");
    end
    // Two words on an external clock that never waits.
    bus(1'b1, NSP_ADDR_CMD, 32'h2, 1'b0);
    for (k = 0; k < 2; k++)
    begin
      w = $random(seed);
      bus(1'b1, NSP_ADDR_TXB, {28'h0, w}, 1'b0);
      q_ser.push_back(w);
      if (k == 0)
        bus(1'b1, NSP_ADDR_CMD, 32'hA, 1'b0);
      ext_go <= 1'b1;
      repeat (2) @(posedge pclk);
      ext_go <= 1'b0;
      wait (got_cnt == 3 + k);
    end
    $display("external transmit test ended");
    results();
  end
endmodule

// ==== test/nsp_core_props.sv ====
// Checker for the serial port core, bound to its top ports.
// Assumes one pclk domain and an APB master that keeps the protocol.
`timescale 1ns/10ps
module nsp_core_props
  import nsp_pkg::*;
(
  // Clock, reset and bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and interrupt.
  input wire logic sck_n_out,
  input wire logic sck_n_oe,
  input wire logic sdo_oe,
  input wire logic serial_buffer_irq
);
  // Command mirror, cycles since its last write, internal falls modulo a word.
  logic [3:0] cmd_r;
  logic [1:0] calm_r;
  logic [1:0] falls_r;
  wire acc = psel && penable && pready;
  wire cmd_wr = acc && pwrite && paddr == NSP_ADDR_CMD;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The mirror lets pin checks wait until the registered outputs settle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_r <= 4'h0;
      calm_r <= 2'h0;
      falls_r <= 2'h0;
    end
    else
    begin
      if (cmd_wr)
        cmd_r <= pwdata[3:0];
      calm_r <= cmd_wr ? 2'h0 : ((calm_r == 2'h3) ? 2'h3 : calm_r + 2'h1);
      if ($fell(sck_n_out))
        falls_r <= falls_r + 2'h1;
    end
  end
  AST_SCK_OE: assert property (calm_r == 2'h3 |-> sck_n_oe == (cmd_r[0] && cmd_r[2:1] != NSP_MODE_BAD))
    else $error("shift clock drive does not follow the command");
  AST_SDO_OE: assert property (calm_r == 2'h3 |-> sdo_oe == (cmd_r[2:1] == NSP_MODE_TX))
    else $error("data output drive does not follow the mode");
  AST_PREADY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer is not one access cycle");
  AST_SLVERR: assert property (psel && !penable && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}) |=> pready && pslverr)
    else $error("unmapped address not refused");
  AST_PAD: assert property (acc && !pwrite |-> prdata[31:4] == 28'h0)
    else $error("upper read bits not zero");
  AST_HALF: assert property ($fell(sck_n_out) |-> ##63 !sck_n_out ##1 sck_n_out)
    else $error("internal clock low phase is not 64 cycles");
  AST_IRQ_CLR: assert property (acc && pwrite && paddr == NSP_ADDR_TXB && cmd_r == 4'hB |=> !serial_buffer_irq || $fell(sck_n_out))
    else $error("buffer write did not clear the request");
  AST_EN_OFF: assert property (calm_r == 2'h3 && !cmd_r[3] && falls_r == 2'h0 && sck_n_out |=> sck_n_out)
    else $error("shift clock ran after the transfer was stopped");
  cover property ($rose(serial_buffer_irq));
  cover property ($fell(sck_n_out));
  cover property (acc && pslverr);
endmodule
bind nsp_core nsp_core_props u_props (.*);

// ==== test/nsp_far_end.sv ====
// Far-end serial circuitry: an external shift clock on request, an 8-bit
// pattern on the data input, and collection of the words sent to it.
// Assumes the bench resolves the clock line from both drivers.
`timescale 1ns/10ps
module nsp_far_end
(
  // Pin levels and bench controls.
  input wire logic sck_line,
  input wire logic sdo_line,
  input wire logic sdo_oe,
  input wire logic ext_go,
  input wire logic [7:0] pattern,
  // Driven pins and collected words.
  output logic sck_ext = 1'b1,
  output logic sdi_line,
  output logic [3:0] got = 4'h0,
  output int got_cnt = 0
);
  // Pattern bit on the line, bits collected, word being collected.
  logic [2:0] idx = 3'h0;
  logic [1:0] nbit = 2'h0;
  logic [3:0] sh = 4'h0;
  assign sdi_line = pattern[idx];
  always @(posedge ext_go)
  begin
    #7;
    repeat (4)
    begin
      #160 sck_ext = 1'b0;
      #160 sck_ext = 1'b1;
    end
  end
  // Data moves 80 ns after each rising edge, clear of both sampling edges.
  initial
  begin
    #1;
    forever
    begin
      @(posedge sck_line);
      #80 idx = idx + 3'h1;
    end
  end
  // Sent bits are taken 300 ns after each leading edge.
  initial
  begin
    #1;
    forever
    begin
      @(negedge sck_line);
      #300;
      if (sdo_oe)
      begin
        sh = {sdo_line, sh[3:1]};
        nbit = nbit + 2'h1;
        if (nbit == 2'h0)
        begin
          got = sh;
          got_cnt = got_cnt + 1;
        end
      end
    end
  end
endmodule

// ==== verilog/nsp_core.sv ====
// Nibble serial port: a 4-bit shift register, a one-nibble buffer and
// the control that moves words between them, behind an APB slave.
// Assumes the shift clock pin idles high before a transfer starts and
// that pin inputs are asynchronous to pclk.
// Limitation: with the external clock an unread receive word can be
// overwritten, because the far side is never held back.
//
// Operation
// R1 - Transmit buffer writes only in transmit mode.
// R2 - Transmit starts only once enable is set.
// R3 - First shift clock loads, sends D0, interrupts.
// R4 - Bits D1-D3 follow, one per shift clock.
// R5 - Buffer write also clears the interrupt.
// R6 - Internal clock halts when transmit buffer empty.
// R7 - Internal clock rate is fc divided by 128.
// R8 - External clock never waits for firmware.
// R9 - Enable cleared: stop after current word.
// R10 - Status MSB shows transfer still active.
// R11 - Enable cleared while waiting: stop now.
// R12 - Four received bits fill buffer, interrupt.
// R13 - Reception continues without waiting for read.
// R14 - Buffer read clears interrupt, moves waiting word.
// R15 - Internal clock halts while received word waits.
// R16 - External receive: firmware reads before next word.
// R17 - Enable cleared: receive stops after current word.
// R18 - Mode change discards buffer contents.
// R19 - Fast stop uses shift progress status bit.
// R20 - Single word receive yields one interrupt.
// R21 - Leading edge receive samples on leading edge.
// R22 - Command bits select mode and clock source.
// R23 - Internal clock driven out; external is input.
// R24 - LSB first out; input shifts toward LSB.
// R25 - External clock must idle high at start.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module nsp_core
  import nsp_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins; the shift clock pin is active low and two-way.
  input wire logic sck_n_in,
  output logic sck_n_out,
  output logic sck_n_oe,
  output logic sdo_out,
  output logic sdo_oe,
  input wire logic sdi_in,
  // Buffer interrupt request to the CPU.
  output logic serial_buffer_irq
);

  // Registered state and its next value.
  // One record keeps every flop in a single clocked process.
  nsp_regs_t state_r;
  nsp_regs_t state_nxt;

  // Decoded command fields.
  // Mode 00 is not allowed; it keeps both pin drivers off.
  logic serial_enable_bit;
  logic clock_source_bit;
  logic [1:0] mode;
  logic tx_mode;
  logic rx_lead;
  // Bus strobes.
  logic bus_setup;
  logic bus_wr;
  logic bus_rd;
  // Shift clock events.
  logic tick;
  logic sck_s;
  logic fall_ev;
  logic rise_ev;
  logic lead_ev;
  logic trail_ev;
  logic [3:0] word;

  // Field decode of the command register held in state.
  // R22 mode select
  assign serial_enable_bit = state_r.cmd[NSP_CMD_EN];
  assign clock_source_bit = state_r.cmd[NSP_CMD_CLK];
  assign mode = state_r.cmd[2:1];
  assign tx_mode = (mode == NSP_MODE_TX);
  assign rx_lead = (mode == NSP_MODE_RXL);

  // Bus phases: setup captures read data; side effects act only on the access edge.
  assign bus_setup = psel & ~penable;
  assign bus_wr = psel & penable & state_r.pready & pwrite;
  assign bus_rd = psel & penable & state_r.pready & ~pwrite;

  // Internal clock toggles every 64 pclk, a full period of 128.
  // R7 divide by 128
  assign tick = &state_r.div;
  // Only the second synchroniser stage is looked at.
  assign sck_s = state_r.sck_sync[1];
  assign fall_ev = state_r.sck_prev & ~sck_s;
  assign rise_ev = ~state_r.sck_prev & sck_s;
  // The pin is active low, so the leading edge is the falling one.
  assign lead_ev = (state_r.st == NSP_RUN) &
    (clock_source_bit ? (tick & state_r.sck_int) : fall_ev);
  assign trail_ev = (state_r.st == NSP_RUN) &
    (clock_source_bit ? (tick & ~state_r.sck_int) : rise_ev);

  // Next-state logic: bus effects first, then the shift engine, so a
  // hardware set of the interrupt in the same cycle wins over a clear.
  always_comb
  begin
    state_nxt = state_r;
    word = 4'h0;
    // Two-stage synchronisers for the asynchronous pins.
    // The first stage may go metastable, so nothing but the second
    // stage is ever read by the logic below.
    state_nxt.sck_sync = {state_r.sck_sync[0], sck_n_in};
    state_nxt.sck_prev = state_r.sck_sync[1];
    state_nxt.sdi_sync = {state_r.sdi_sync[0], sdi_in};

    // Zero wait states: ready follows the setup cycle.
    state_nxt.pready = bus_setup;
    if (bus_setup)
    begin
      state_nxt.pslverr = 1'b0;
      state_nxt.prdata = 32'h0000_0000;
      // Read data is captured at setup; the side effect waits for access.
      if (paddr == NSP_ADDR_CMD)
      begin
        state_nxt.prdata[3:0] = state_r.cmd;
      end
      else if (paddr == NSP_ADDR_STAT)
      begin
        // Status is sampled at setup, one cycle before the access edge.
        // R10 active flag
        state_nxt.prdata[NSP_ST_ACT] = (state_r.st != NSP_IDLE);
        // R19 shift progress
        state_nxt.prdata[NSP_ST_SHF] = (state_r.cnt != 3'h0);
        state_nxt.prdata[NSP_ST_FULL] = state_r.buf_full;
        state_nxt.prdata[NSP_ST_IRQ] = state_r.irq;
      end
      else if (paddr == NSP_ADDR_RXB)
      begin
        state_nxt.prdata[3:0] = state_r.buf_q;
      end
      else if (paddr != NSP_ADDR_TXB)
      begin
        // Unmapped addresses answer with an error.
        state_nxt.pslverr = 1'b1;
      end
    end

    // Only one register access can land per cycle, so the chain below
    // never has to merge two bus effects.
    // Command register write.
    if (bus_wr && paddr == NSP_ADDR_CMD)
    begin
      state_nxt.cmd = pwdata[3:0];
      // R18 mode change discards
      if (pwdata[2:1] != mode)
      begin
        state_nxt.buf_full = 1'b0;
        state_nxt.pend = 1'b0;
        state_nxt.irq = 1'b0;
      end
    end
    // R1 transmit mode only
    else if (bus_wr && paddr == NSP_ADDR_TXB && tx_mode)
    begin
      state_nxt.buf_q = pwdata[3:0];
      state_nxt.buf_full = 1'b1;
      // R5 write clears request
      state_nxt.irq = 1'b0;
    end
    // R14 read clears request
    else if (bus_rd && paddr == NSP_ADDR_RXB && !tx_mode)
    begin
      state_nxt.irq = 1'b0;
      state_nxt.buf_full = 1'b0;
      if (state_r.pend)
      begin
        // A finished word held back is moved in and announced again.
        // With the external clock the held word may already carry new
        // bits; the far side must pace itself to avoid that.
        state_nxt.buf_q = state_r.shreg;
        state_nxt.buf_full = 1'b1;
        state_nxt.irq = 1'b1;
        state_nxt.pend = 1'b0;
      end
    end

    // Pin drivers follow the command that is in force.
    // R23 internal clock out
    state_nxt.sck_oe = state_nxt.cmd[NSP_CMD_CLK] & (state_nxt.cmd[2:1] != NSP_MODE_BAD);
    state_nxt.sdo_oe = (state_nxt.cmd[2:1] == NSP_MODE_TX);

    // Shift engine.
    // It reads the enable bit, and in idle every command field, through
    // state_nxt so that such a write takes effect at once, not one cycle late.
    case (state_r.st)
      // Idle parks the internal clock high, so a new start meets the
      // idle level that the far side expects.
      NSP_IDLE:
      begin
        state_nxt.sck_int = 1'b1;
        state_nxt.div = '0;
        state_nxt.cnt = 3'h0;
        // R2 start on enable
        if (state_nxt.cmd[NSP_CMD_EN] && state_nxt.cmd[2:1] != NSP_MODE_BAD)
        begin
          // R6 no data, wait
          if (state_nxt.cmd[2:1] == NSP_MODE_TX && state_nxt.cmd[NSP_CMD_CLK] &&
              !state_nxt.buf_full)
          begin
            state_nxt.st = NSP_WAIT;
          end
          else
          begin
            state_nxt.st = NSP_RUN;
          end
        end
      end
      NSP_WAIT:
      begin
        // The clock pin is parked high while waiting.
        // The divider is held cleared, so the clock restarts with a
        // full half period once data or room appears.
        state_nxt.sck_int = 1'b1;
        state_nxt.div = '0;
        // R11 stop at once
        if (!state_nxt.cmd[NSP_CMD_EN])
        begin
          state_nxt.st = NSP_IDLE;
        end
        else if (tx_mode ? state_nxt.buf_full : !state_nxt.pend)
        begin
          state_nxt.st = NSP_RUN;
        end
      end
      // The divider only runs while shifting, so every frame starts
      // with a full high half period.
      NSP_RUN:
      begin
        if (clock_source_bit)
        begin
          state_nxt.div = state_r.div + 1'b1;
          if (tick)
          begin
            state_nxt.sck_int = ~state_r.sck_int;
          end
        end
        // Leading edges count bits; the count stops at four so that the
        // closing trailing edge still finds the word complete.
        if (lead_ev)
        begin
          if (tx_mode)
          begin
            if (state_r.cnt == 3'h0)
            begin
              // R3 load and interrupt
              if (state_nxt.buf_full)
              begin
                state_nxt.shreg = state_nxt.buf_q;
                state_nxt.buf_full = 1'b0;
                state_nxt.irq = 1'b1;
              end
              // R24 LSB first
              state_nxt.sdo = state_nxt.shreg[0];
            end
            else
            begin
              // R4 remaining bits
              state_nxt.shreg = {1'b0, state_r.shreg[3:1]};
              state_nxt.sdo = state_r.shreg[1];
            end
          end
          else if (rx_lead)
          begin
            // R21 sample on leading edge
            state_nxt.shreg = {state_r.sdi_sync[1], state_r.shreg[3:1]};
          end
          if (state_r.cnt != NSP_WORD_BITS)
          begin
            state_nxt.cnt = state_r.cnt + 3'h1;
          end
        end
        if (trail_ev)
        begin
          // R24 shift toward LSB
          if (mode == NSP_MODE_RXT)
          begin
            state_nxt.shreg = {state_r.sdi_sync[1], state_r.shreg[3:1]};
          end
          // The trailing edge after the fourth bit closes the word.
          if (state_r.cnt == NSP_WORD_BITS)
          begin
            state_nxt.cnt = 3'h0;
            word = state_nxt.shreg;
            if (!tx_mode)
            begin
              // R12 word to buffer
              if (!state_nxt.buf_full)
              begin
                state_nxt.buf_q = word;
                state_nxt.buf_full = 1'b1;
                state_nxt.irq = 1'b1;
              end
              else
              begin
                // R13 keep shifting
                state_nxt.pend = 1'b1;
              end
            end
            // R9 stop after word
            // R17 stop after word
            // R20 one word stop
            if (!state_nxt.cmd[NSP_CMD_EN])
            begin
              state_nxt.st = NSP_IDLE;
            end
            // R6 halt clock
            // R15 halt clock
            // R8 external never waits
            // R16 external receive overruns
            else if (clock_source_bit &&
                     (tx_mode ? !state_nxt.buf_full : state_nxt.pend))
            begin
              state_nxt.st = NSP_WAIT;
            end
          end
        end
      end
      default:
      begin
        state_nxt.st = NSP_IDLE;
      end
    endcase
  end

  // State register; reset loads constants only.
  // Synchroniser stages reset to the pin idle level, so no false edge
  // is seen right after reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= '{st: NSP_IDLE, cmd: NSP_CMD_RST, buf_q: 4'h0, shreg: 4'h0,
                   cnt: 3'h0, buf_full: 1'b0, pend: 1'b0, irq: 1'b0, div: '0,
                   sck_int: 1'b1, sdo: 1'b1, sck_oe: 1'b0, sdo_oe: 1'b0,
                   sck_sync: 2'h3, sck_prev: 1'b1, sdi_sync: 2'h3, pready: 1'b0,
                   pslverr: 1'b0, prdata: 32'h0000_0000};
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Outputs come straight from the state register.
  // The pin drivers are flops too, so no decode glitch reaches a pad.
  assign prdata = state_r.prdata;
  assign pready = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign sck_n_out = state_r.sck_int;
  assign sck_n_oe = state_r.sck_oe;
  assign sdo_out = state_r.sdo;
  assign sdo_oe = state_r.sdo_oe;
  assign serial_buffer_irq = state_r.irq;

endmodule

// ==== verilog/nsp_pkg.sv ====
// Constants and state type of the nibble serial port.
// Assumes a single pclk domain; pins are synchronised in the core.
package nsp_pkg;
  // APB byte addresses of the four registers.
  localparam logic [7:0] NSP_ADDR_CMD = 8'h00;
  localparam logic [7:0] NSP_ADDR_STAT = 8'h04;
  localparam logic [7:0] NSP_ADDR_TXB = 8'h08;
  localparam logic [7:0] NSP_ADDR_RXB = 8'h0C;
  // Command register fields.
  localparam int NSP_CMD_EN = 3;
  localparam int NSP_CMD_CLK = 0;
  localparam logic [3:0] NSP_CMD_RST = 4'h0;
  // Mode field (command bits 2:1).
  localparam logic [1:0] NSP_MODE_BAD = 2'h0;
  localparam logic [1:0] NSP_MODE_TX = 2'h1;
  localparam logic [1:0] NSP_MODE_RXT = 2'h2;
  localparam logic [1:0] NSP_MODE_RXL = 2'h3;
  // Status bits.
  localparam int NSP_ST_ACT = 3;
  localparam int NSP_ST_SHF = 2;
  localparam int NSP_ST_FULL = 1;
  localparam int NSP_ST_IRQ = 0;
  // Bits per word and the internal shift clock divider: fc/2^7.
  localparam logic [2:0] NSP_WORD_BITS = 3'h4;
  localparam int NSP_DIV_LOG2 = 7;
  localparam int NSP_DIV_W = NSP_DIV_LOG2 - 1;
  // Transfer engine states.
  typedef enum logic [1:0] {
    NSP_IDLE = 2'b00,
    NSP_RUN = 2'b01,
    NSP_WAIT = 2'b10
  } nsp_state_t;
  // All state of the core in one record.
  typedef struct packed {
    nsp_state_t st;
    logic [3:0] cmd;
    logic [3:0] buf_q;
    logic [3:0] shreg;
    logic [2:0] cnt;
    logic buf_full;
    logic pend;
    logic irq;
    logic [NSP_DIV_W-1:0] div;
    logic sck_int;
    logic sdo;
    logic sck_oe;
    logic sdo_oe;
    logic [1:0] sck_sync;
    logic sck_prev;
    logic [1:0] sdi_sync;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } nsp_regs_t;
endpackage
